// ### design/bcc_pkg.sv
// bcc_pkg: constants, cycle codes, states and helpers of the bus cycle control.
// assumes one bus clock; every user of it imports the whole package.
package bcc_pkg;

	// ************************************************************
	// widths and timing
	// ************************************************************
	localparam int ADDR_W = 29;
	localparam int DATA_W = 64;
	localparam int BE_W = 8;
	localparam int BURST_BEATS = 4;
	localparam int BEAT_W = 2;
	localparam int CLK_PERIOD_NS = 4;

	// ************************************************************
	// cycle types requested by the core
	// ************************************************************
	typedef enum logic [2:0] {
		CYC_CODE_RD = 3'h0,
		CYC_MEM_RD = 3'h1,
		CYC_MEM_WR = 3'h2,
		CYC_IO_RD = 3'h3,
		CYC_IO_WR = 3'h4,
		CYC_INTA = 3'h5,
		CYC_SPECIAL = 3'h6
	} bcc_cyc_t;

	// qualifier triplets {memIo, dataCode, writeRead}; dataCode high means data
	localparam logic [2:0] QUAL_CODE_RD = 3'h4;
	localparam logic [2:0] QUAL_MEM_RD = 3'h6;
	localparam logic [2:0] QUAL_MEM_WR = 3'h7;
	localparam logic [2:0] QUAL_IO_RD = 3'h2;
	localparam logic [2:0] QUAL_IO_WR = 3'h3;
	localparam logic [2:0] QUAL_INTA = 3'h0;
	localparam logic [2:0] QUAL_SPECIAL = 3'h1;

	// ************************************************************
	// bus sequencer states
	// ************************************************************
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ADDR = 4'h2,
		ST_DATA = 4'h4,
		ST_HOLD = 4'h8
	} bcc_state_t;

	// even parity bit for each byte of the data bus
	function automatic logic [BE_W-1:0] bytePar(input logic [DATA_W-1:0] d);
		logic [BE_W-1:0] p;
		p = '0;
		for (int i = 0; i < BE_W; i++) begin
			p[i] = ^d[i*8 +: 8];
		end
		return p;
	endfunction

	// either ready copy completes a transfer
	function automatic logic readyOf(input logic rdyN, input logic rdyDupN);
		return !rdyN || !rdyDupN;
	endfunction

endpackage

// ### design/bcc_cyc_if.sv
// bcc_cyc_if: cycle decode and beat tracking signals between sequencer and helpers.
// assumes a single clock domain; carries no clock of its own.
`timescale 1ns/1ns
interface bcc_cyc_if;
	import bcc_pkg::*;
	bcc_cyc_t cycType;
	logic cacheable;
	logic memIoQ;
	logic dataCodeQ;
	logic writeReadQ;
	logic cacheQ;
	logic burstQ;
	logic beatClr;
	logic beatHit;
	logic lastBeat;
	modport seq (output cycType, cacheable, beatClr, beatHit,
		input memIoQ, dataCodeQ, writeReadQ, cacheQ, burstQ, lastBeat);
	modport enc (input cycType, cacheable, output memIoQ, dataCodeQ, writeReadQ, cacheQ, burstQ);
	modport cnt (input beatClr, beatHit, burstQ, output lastBeat);
endinterface

// ### design/bcc_cycle_encode.sv
// bcc_cycle_encode: turns a cycle type into bus qualifiers and the cache qualifier.
// assumes cacheable means "line fill" on reads and "modified writeback" on writes.
`timescale 1ns/1ns
module bcc_cycle_encode import bcc_pkg::*; (
	bcc_cyc_if.enc cy
);
	logic [2:0] qual;

	always_comb begin
		qual = QUAL_INTA;
		cy.cacheQ = 1'b0;
		case (cy.cycType)
			CYC_CODE_RD: begin
				qual = QUAL_CODE_RD;
				cy.cacheQ = cy.cacheable;
			end
			CYC_MEM_RD: begin
				qual = QUAL_MEM_RD;
				cy.cacheQ = cy.cacheable;
			end
			CYC_MEM_WR: begin
				qual = QUAL_MEM_WR;
				cy.cacheQ = cy.cacheable;
			end
			CYC_IO_RD: qual = QUAL_IO_RD;
			CYC_IO_WR: qual = QUAL_IO_WR;
			CYC_INTA: qual = QUAL_INTA;
			CYC_SPECIAL: qual = QUAL_SPECIAL;
			default: qual = QUAL_INTA;
		endcase
	end

	assign cy.memIoQ = qual[2];
	assign cy.dataCodeQ = qual[1];
	assign cy.writeReadQ = qual[0];
	// only cache line transfers burst; everything else is a single transfer
	assign cy.burstQ = cy.cacheQ;

endmodule

// ### design/bcc_beat_counter.sv
// bcc_beat_counter: counts completed transfers of the current bus cycle.
// assumes beatClr is held whenever no data phase is running.
`timescale 1ns/1ns
module bcc_beat_counter import bcc_pkg::*; #(
	parameter int BEATS = BURST_BEATS
) (
	input wire logic core_clk,
	input wire logic rst,
	bcc_cyc_if.cnt cy
);
	logic [BEAT_W-1:0] beatCnt_reg;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			beatCnt_reg <= '0;
		end else if (cy.beatClr) begin
			beatCnt_reg <= '0;
		end else if (cy.beatHit) begin
			beatCnt_reg <= beatCnt_reg + 1'b1;
		end
	end

	assign cy.lastBeat = !cy.burstQ || (beatCnt_reg == BEAT_W'(BEATS - 1));

	a_beat_bound: assert property (@(posedge core_clk) disable iff (rst)
		cy.beatHit && cy.lastBeat |=> beatCnt_reg == '0 || cy.beatClr)
		else $error("beat count ran past the last transfer");

endmodule

// ### design/bcc_bus_ctrl.sv
// bcc_bus_ctrl: front-side bus cycle sequencer with backoff, ready and qualifiers.
// assumes all pins are sampled and driven on core_clk; pins split into out and enable.
`timescale 1ns/1ns
module bcc_bus_ctrl import bcc_pkg::*; (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic cycReq,
	input wire bcc_cyc_t cycType,
	input wire logic [ADDR_W-1:0] cycAddr,
	input wire logic [BE_W-1:0] cycByteEn,
	input wire logic [DATA_W-1:0] cycWrData,
	input wire logic cycCacheable,
	input wire logic cycLock,
	input wire logic cycPcd,
	input wire logic cycPwt,
	input wire logic cycSplit,
	output logic cycBusy,
	output logic cycDone,
	output logic cycAborted,
	output logic rdValid,
	output logic [DATA_W-1:0] rdData,
	input wire logic backoff_n,
	input wire logic burst_ready_n,
	input wire logic burst_ready_dup_n,
	output logic bus_request,
	output logic busOe,
	output logic [ADDR_W-1:0] busAddr,
	output logic addr_strobe_n,
	output logic addr_strobe_dup_n,
	output logic address_parity,
	output logic [BE_W-1:0] byte_enable_n,
	output logic cacheN,
	output logic memIo,
	output logic dataCode,
	output logic writeRead,
	output logic lockN,
	output logic page_cache_disable,
	output logic page_write_through,
	output logic split_cycle,
	input wire logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] dataOut,
	output logic [BE_W-1:0] data_parity,
	output logic dataOe
);
	// ************************************************************
	// pending cycle and decode helpers
	// ************************************************************
	bcc_state_t state_reg;
	logic pendValid_reg;
	bcc_cyc_t pendType_reg;
	logic [ADDR_W-1:0] pendAddr_reg;
	logic [BE_W-1:0] pendBe_reg;
	logic [DATA_W-1:0] pendData_reg;
	logic pendCache_reg;
	logic pendLock_reg;
	logic pendPcd_reg;
	logic pendPwt_reg;
	logic pendSplit_reg;
	logic cycDone_reg;
	logic cycAborted_reg;
	logic rdValid_reg;
	logic [DATA_W-1:0] rdData_reg;
	logic busOe_reg;
	logic dataOe_reg;
	logic strobeN_reg;
	logic [ADDR_W-1:0] busAddr_reg;
	logic addrPar_reg;
	logic [BE_W-1:0] beN_reg;
	logic cacheN_reg;
	logic memIo_reg;
	logic dataCode_reg;
	logic writeRead_reg;
	logic lockN_reg;
	logic pcd_reg;
	logic pwt_reg;
	logic split_reg;
	logic [DATA_W-1:0] dataOut_reg;
	logic [BE_W-1:0] dataPar_reg;

	logic readyHit;
	logic launch;
	logic done;
	logic accept;

	bcc_cyc_if cy ();

	bcc_cycle_encode u_encode (
		.cy(cy)
	);

	bcc_beat_counter #(.BEATS(BURST_BEATS)) u_beats (
		.core_clk(core_clk),
		.rst(rst),
		.cy(cy)
	);

	assign cy.cycType = pendType_reg;
	assign cy.cacheable = pendCache_reg;
	assign readyHit = readyOf(burst_ready_n, burst_ready_dup_n);
	assign accept = cycReq && !pendValid_reg;
	// a launch or a transfer never happens in a cycle where backoff is sampled low
	assign launch = backoff_n && state_reg == ST_IDLE && pendValid_reg;
	assign done = backoff_n && state_reg == ST_DATA && readyHit && cy.lastBeat;
	assign cy.beatClr = state_reg != ST_DATA;
	assign cy.beatHit = backoff_n && state_reg == ST_DATA && readyHit;

	// ************************************************************
	// sequencer
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
		end else if (!backoff_n) begin
			state_reg <= ST_HOLD;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (pendValid_reg) begin
						state_reg <= ST_ADDR;
					end
				end
				ST_ADDR: state_reg <= ST_DATA;
				ST_DATA: begin
					if (done) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_HOLD: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// an aborted cycle stays pending and restarts from its address phase
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pendValid_reg <= 1'b0;
			pendType_reg <= CYC_MEM_RD;
			pendAddr_reg <= '0;
			pendBe_reg <= '0;
			pendData_reg <= '0;
			pendCache_reg <= 1'b0;
			pendLock_reg <= 1'b0;
			pendPcd_reg <= 1'b0;
			pendPwt_reg <= 1'b0;
			pendSplit_reg <= 1'b0;
		end else if (accept) begin
			pendValid_reg <= 1'b1;
			pendType_reg <= cycType;
			pendAddr_reg <= cycAddr;
			pendBe_reg <= cycByteEn;
			pendData_reg <= cycWrData;
			pendCache_reg <= cycCacheable;
			pendLock_reg <= cycLock;
			pendPcd_reg <= cycPcd;
			pendPwt_reg <= cycPwt;
			pendSplit_reg <= cycSplit;
		end else if (done) begin
			pendValid_reg <= 1'b0;
		end
	end

	// ************************************************************
	// core side answers
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cycDone_reg <= 1'b0;
			cycAborted_reg <= 1'b0;
			rdValid_reg <= 1'b0;
			rdData_reg <= '0;
		end else begin
			cycDone_reg <= done;
			cycAborted_reg <= !backoff_n && (state_reg == ST_ADDR || state_reg == ST_DATA);
			rdValid_reg <= cy.beatHit && !cy.writeReadQ;
			if (cy.beatHit && !cy.writeReadQ) begin
				rdData_reg <= dataIn;
			end
		end
	end

	// ************************************************************
	// pin drivers
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busOe_reg <= 1'b0;
			dataOe_reg <= 1'b0;
			strobeN_reg <= 1'b1;
		end else begin
			busOe_reg <= backoff_n;
			dataOe_reg <= backoff_n && cy.writeReadQ &&
				(state_reg == ST_ADDR || (state_reg == ST_DATA && !done));
			strobeN_reg <= !launch;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busAddr_reg <= '0;
			addrPar_reg <= 1'b0;
			beN_reg <= '1;
			cacheN_reg <= 1'b1;
			memIo_reg <= 1'b0;
			dataCode_reg <= 1'b0;
			writeRead_reg <= 1'b0;
			lockN_reg <= 1'b1;
			pcd_reg <= 1'b0;
			pwt_reg <= 1'b0;
			split_reg <= 1'b0;
			dataOut_reg <= '0;
			dataPar_reg <= '0;
		end else if (launch) begin
			busAddr_reg <= pendAddr_reg;
			addrPar_reg <= ^pendAddr_reg;
			beN_reg <= ~pendBe_reg;
			cacheN_reg <= !cy.cacheQ;
			memIo_reg <= cy.memIoQ;
			dataCode_reg <= cy.dataCodeQ;
			writeRead_reg <= cy.writeReadQ;
			lockN_reg <= !pendLock_reg;
			pcd_reg <= pendPcd_reg;
			pwt_reg <= pendPwt_reg;
			split_reg <= pendSplit_reg;
			dataOut_reg <= pendData_reg;
			dataPar_reg <= bytePar(pendData_reg);
		end
	end

	assign cycBusy = pendValid_reg;
	assign bus_request = pendValid_reg;
	assign cycDone = cycDone_reg;
	assign cycAborted = cycAborted_reg;
	assign rdValid = rdValid_reg;
	assign rdData = rdData_reg;
	assign busOe = busOe_reg;
	assign dataOe = dataOe_reg;
	assign addr_strobe_n = strobeN_reg;
	assign addr_strobe_dup_n = strobeN_reg;
	assign busAddr = busAddr_reg;
	assign address_parity = addrPar_reg;
	assign byte_enable_n = beN_reg;
	assign cacheN = cacheN_reg;
	assign memIo = memIo_reg;
	assign dataCode = dataCode_reg;
	assign writeRead = writeRead_reg;
	assign lockN = lockN_reg;
	assign page_cache_disable = pcd_reg;
	assign page_write_through = pwt_reg;
	assign split_cycle = split_reg;
	assign dataOut = dataOut_reg;
	assign data_parity = dataPar_reg;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_backoffSeen;
		!backoff_n;
	endsequence

	sequence s_floated;
		!busOe && !dataOe;
	endsequence

	a_backoff_floats: assert property (s_backoffSeen |=> s_floated)
		else $error("bus not floated after backoff");
	a_hold_all_pins: assert property (s_backoffSeen ##1 s_backoffSeen |=> s_floated ##0 state_reg == ST_HOLD)
		else $error("bus driven while hold continues");
	a_hold_release: assert property (state_reg == ST_HOLD && backoff_n |=> busOe && state_reg == ST_IDLE)
		else $error("bus not retaken after backoff release");
	a_dup_ready: assert property (backoff_n && state_reg == ST_DATA && burst_ready_n && !burst_ready_dup_n
		&& cy.lastBeat |=> cycDone && !bus_request)
		else $error("ready copy did not end the cycle");
	a_ready_ends: assert property (done |=> cycDone ##1 !cycDone)
		else $error("cycle end not reported once");
	a_request_pending: assert property (cycReq && !cycBusy |=> bus_request throughout (!cycDone [*1]))
		else $error("bus request missing for pending cycle");
	a_cache_qual: assert property ($fell(addr_strobe_n) |-> cacheN == !(pendCache_reg
		&& (pendType_reg == CYC_CODE_RD || pendType_reg == CYC_MEM_RD || pendType_reg == CYC_MEM_WR)))
		else $error("cache qualifier wrong for cycle");
	a_strobe_once: assert property ($fell(addr_strobe_n) |=> addr_strobe_n)
		else $error("address strobe longer than one clock");
	a_code_fetch: assert property ($fell(addr_strobe_n) && pendType_reg == CYC_CODE_RD |-> !dataCode && memIo)
		else $error("code fetch not marked as code");
	a_byte_lanes: assert property (dataOe |-> byte_enable_n == ~pendBe_reg && writeRead)
		else $error("write data without matching byte enables");

endmodule

// ### tb/bcc_sys_model.sv
// bcc_sys_model: system logic that answers bus cycles with ready and read data.
// assumes the strobe and cache qualifier of bcc_bus_ctrl; backoff comes from the bench.
`timescale 1ns/1ns
module bcc_sys_model import bcc_pkg::*; #(
	parameter logic [DATA_W-1:0] PAT = 64'h0
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic addr_strobe_n,
	input wire logic cacheN,
	input wire logic [DATA_W-1:0] dataOut,
	input wire logic [3:0] waitCyc,
	input wire logic useDup,
	output logic burst_ready_n,
	output logic burst_ready_dup_n,
	output logic [DATA_W-1:0] dataIn,
	output logic [DATA_W-1:0] wrSeen
);
	int left;
	int dly;
	logic [DATA_W-1:0] beat;
	logic rdy;
	assign rdy = left > 0 && dly == 0;
	assign burst_ready_n = !(rdy && !useDup);
	assign burst_ready_dup_n = !(rdy && useDup);
	// outside a ready the data is inverted, never a stale copy
	assign dataIn = rdy ? PAT ^ beat : ~(PAT ^ beat);
	// a new strobe restarts the answer, so a backed-off cycle is served afresh
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			left <= 0;
			dly <= 0;
			beat <= '0;
			wrSeen <= '0;
		end else if (!addr_strobe_n) begin
			left <= cacheN ? 1 : BURST_BEATS;
			dly <= int'(waitCyc);
			beat <= '0;
		end else if (rdy) begin
			left <= left - 1;
			beat <= beat + 64'h1;
			wrSeen <= dataOut;
		end else if (dly > 0) begin
			dly <= dly - 1;
		end
	end
endmodule

// ### tb/bcc_bus_ctrl_tb.sv
// bcc_bus_ctrl_tb: self-checking bench for the bus cycle sequencer.
// assumes bcc_sys_model gives ready and read data; backoff is driven here.
`timescale 1ns/1ns
module bcc_bus_ctrl_tb import bcc_pkg::*;;
	localparam logic [DATA_W-1:0] PAT = 64'h0123_4567_89AB_CDEF;
	typedef struct {
		bcc_cyc_t t;
		logic c;
		logic [BE_W-1:0] be;
		logic [3:0] w;
		logic d;
		logic [2:0] q;
		int nb;
	} bcc_row_t;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic cycReq = 1'b0;
	bcc_cyc_t cycType = CYC_CODE_RD;
	logic [ADDR_W-1:0] cycAddr = '0;
	logic [BE_W-1:0] cycByteEn = '0;
	logic [DATA_W-1:0] cycWrData = '0;
	logic cycCacheable = 1'b0, cycLock = 1'b0, cycPcd = 1'b0, cycPwt = 1'b0, cycSplit = 1'b0;
	logic backoff_n = 1'b1;
	logic [3:0] waitCyc = 4'h0;
	logic useDup = 1'b0;
	logic cycBusy, cycDone, cycAborted, rdValid, bus_request, busOe, addr_strobe_n, addr_strobe_dup_n;
	logic address_parity, cacheN, memIo, dataCode, writeRead, lockN, dataOe, burst_ready_n, burst_ready_dup_n;
	logic page_cache_disable, page_write_through, split_cycle;
	logic [ADDR_W-1:0] busAddr;
	logic [BE_W-1:0] byte_enable_n, data_parity;
	logic [DATA_W-1:0] rdData, dataIn, dataOut, wrSeen;
	int fails = 0;
	int n_checks = 0;
	bcc_row_t cur;
	bcc_row_t bo = '{CYC_MEM_RD, 1'b1, 8'hFF, 4'h3, 1'b0, QUAL_MEM_RD, 4};
	bcc_row_t rows [8] = '{
		'{CYC_CODE_RD, 1'b1, 8'hFF, 4'h0, 1'b0, QUAL_CODE_RD, 4},
		'{CYC_MEM_RD, 1'b0, 8'h01, 4'h2, 1'b1, QUAL_MEM_RD, 1},
		'{CYC_MEM_WR, 1'b1, 8'hFF, 4'h1, 1'b1, QUAL_MEM_WR, 4},
		'{CYC_MEM_WR, 1'b0, 8'hC3, 4'h0, 1'b0, QUAL_MEM_WR, 1},
		'{CYC_IO_RD, 1'b0, 8'h80, 4'h0, 1'b0, QUAL_IO_RD, 1},
		'{CYC_IO_WR, 1'b0, 8'h3C, 4'h3, 1'b0, QUAL_IO_WR, 1},
		'{CYC_INTA, 1'b0, 8'h00, 4'h0, 1'b1, QUAL_INTA, 1},
		'{CYC_SPECIAL, 1'b0, 8'h04, 4'h1, 1'b0, QUAL_SPECIAL, 1}
	};

	bcc_bus_ctrl DUT (.core_clk, .rst, .cycReq, .cycType, .cycAddr, .cycByteEn, .cycWrData, .cycCacheable,
		.cycLock, .cycPcd, .cycPwt, .cycSplit, .cycBusy, .cycDone, .cycAborted, .rdValid, .rdData, .backoff_n,
		.burst_ready_n, .burst_ready_dup_n, .bus_request, .busOe, .busAddr, .addr_strobe_n, .addr_strobe_dup_n,
		.address_parity, .byte_enable_n, .cacheN, .memIo, .dataCode, .writeRead, .lockN, .page_cache_disable,
		.page_write_through, .split_cycle, .dataIn, .dataOut, .data_parity, .dataOe);
	bcc_sys_model #(.PAT(PAT)) sys (.core_clk, .rst, .addr_strobe_n, .cacheN, .dataOut, .waitCyc, .useDup,
		.burst_ready_n, .burst_ready_dup_n, .dataIn, .wrSeen);

	always #2 core_clk = ~core_clk;

	// ****************
	// bench tasks
	// ****************
	// even parity per byte, worked bit by bit so it shares nothing with the design
	function automatic logic [BE_W-1:0] evenPar(input logic [DATA_W-1:0] d);
		logic [BE_W-1:0] p;
		p = '0;
		for (int b = 0; b < DATA_W; b++) begin
			p[b / 8] = p[b / 8] ^ d[b];
		end
		return p;
	endfunction

	// an unknown result counts as a mismatch
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic issue(input bcc_row_t r, input int i);
		cur = r;
		@(posedge core_clk);
		cycReq <= 1'b1;
		cycType <= r.t;
		cycCacheable <= r.c;
		cycByteEn <= r.be;
		cycAddr <= ADDR_W'(i + 1);
		cycWrData <= {PAT[31:0], PAT[63:32]} ^ DATA_W'(i);
		cycLock <= i[0];
		cycPcd <= i[1];
		cycPwt <= i[2];
		cycSplit <= ~i[0];
		waitCyc <= r.w;
		useDup <= r.d;
		@(posedge core_clk);
		cycReq <= 1'b0;
	endtask

	// counts readies up to the done pulse; the bound cuts a hung cycle short
	task automatic waitDone(input int nb);
		int n;
		int k;
		logic wr;
		n = 0;
		wr = cur.t == CYC_MEM_WR || cur.t == CYC_IO_WR;
		for (k = 0; k < 60; k++) begin
			@(posedge core_clk);
			#1;
			if (cycDone === 1'b1) break;
			chk(bus_request === 1'b1, "no bus request");
			if (addr_strobe_n === 1'b0) begin
				chk(busOe === 1'b1 && {memIo, dataCode, writeRead} === cur.q, "qualifiers");
				chk(cacheN === !cur.c, "cache qualifier");
				chk(byte_enable_n === ~cur.be, "byte enables");
				chk(busAddr === cycAddr && address_parity === ^cycAddr && addr_strobe_dup_n === 1'b0, "address");
				chk({lockN, page_cache_disable, page_write_through, split_cycle}
					=== {~cycLock, cycPcd, cycPwt, cycSplit}, "attributes");
			end
			if (!burst_ready_n || !burst_ready_dup_n) begin
				n++;
				if (wr) chk(dataOe === 1'b1 && dataOut === cycWrData, "write data");
				if (wr) chk(data_parity === evenPar(cycWrData), "data parity");
			end
		end
		chk(k < 60 && n == nb, "ready count");
		if (wr) chk(wrSeen === cycWrData, "latched data");
		else if (cur.t != CYC_SPECIAL) chk(rdValid === 1'b1 && rdData === (PAT ^ DATA_W'(nb - 1)), "read");
	endtask

	// ****************
	// sequence
	// ****************
	initial begin
		repeat (3) @(posedge core_clk);
		chk(busOe === 1'b0 && dataOe === 1'b0 && bus_request === 1'b0 && byte_enable_n === 8'hFF, "reset");
		rst <= 1'b0;
		$display("reset done");
		foreach (rows[i]) begin
			issue(rows[i], i);
			waitDone(rows[i].nb);
			$display("row %0d done", i);
		end
		issue(bo, 9);
		for (int k = 0; k < 10 && addr_strobe_n !== 1'b0; k++) begin
			@(posedge core_clk);
			#1;
		end
		@(posedge core_clk);
		backoff_n <= 1'b0;
		// held past the model's stray readies, which must be ignored
		for (int j = 0; j < 8; j++) begin
			@(posedge core_clk);
			#1;
			chk(busOe === 1'b0 && dataOe === 1'b0 && bus_request === 1'b1 && rdValid === 1'b0 && cycDone === 1'b0,
				"not floated");
			if (j == 0) chk(cycAborted === 1'b1, "no abort");
		end
		@(posedge core_clk);
		backoff_n <= 1'b1;
		waitDone(4);
		$display("backoff done");
		issue(rows[2], 2);
		repeat (3) @(posedge core_clk);
		rst <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(cycBusy === 1'b0 && busOe === 1'b0 && dataOe === 1'b0, "mid reset");
		@(posedge core_clk);
		rst <= 1'b0;
		issue(rows[1], 1);
		waitDone(1);
		$display("second reset done");
		test_done();
	end

	initial begin
		#40000;
		fails++;
		test_done();
	end
endmodule
